/* logic/mac_port_congestion_ctrl.sv */
// Per-port back pressure, PAUSE, storm and self-address control
// Contract
// - Back pressure starts and stops on the same resource state as PAUSE.
// - Carrier is forced on the half-duplex port while back pressure is on.
// - Carrier drops briefly after a bounded time, then returns quickly.
// - Queued transmit frames suspend carrier back pressure and go out; after a collision, they no longer do until back pressure ends.
// - With nothing queued, carrier back pressure resumes until resources free.
// - Collision under back pressure skips back-off, forces carrier at once.
// - PAUSE frames carry the programmed switch MAC as source address.
// - Default flow control and back pressure enable come from the strap.
// - Per-port flow and back pressure enables, global mode and fair mode.
// - Global pass-PAUSE setting and aggressive back-off enable.
// - Storm rates global, enabled per port, optional multicast counting.
// - Storm interval is 50 ms at 100 Mbit/s and 500 ms at 10.
// - Byte counter clears each interval, counts storm bytes, limits at threshold.
// - Storm threshold resets to one percent of line rate.
// - Frames with source equal to switch MAC are dropped when enabled.
// - Shortage sends maximum pause time; recovery sends zero pause time.
// - Sixteen consecutive collisions discard the frame unless disabled; collisions while back pressure is requested are not counted.
`timescale 1ns/1ps
module mac_port_congestion_ctrl #(
	parameter int unsigned INTERVAL_100_CYC =
		cong_pkg::STORM_INTERVAL_100_MS * 1000000 / cong_pkg::CLK_PERIOD_NS,
	parameter int unsigned INTERVAL_10_CYC =
		cong_pkg::STORM_INTERVAL_10_MS * 1000000 / cong_pkg::CLK_PERIOD_NS
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic FLOW_CTRL_STRAP_PIN_I,
	input wire logic RES_SHORT_I,
	input wire logic RES_OK_I,
	input wire logic FULL_DUPLEX_I,
	input wire logic SPEED_100_I,
	input wire logic TX_PENDING_I,
	input wire logic TX_BUSY_I,
	input wire logic COLLISION_I,
	input wire logic TX_DONE_I,
	input wire logic RX_BYTE_I,
	input wire logic RX_BCAST_I,
	input wire logic RX_MCAST_I,
	input wire logic RX_SA_VALID_I,
	input wire logic [47:0] RX_SA_I,
	output logic CRS_FORCE_O,
	output logic SKIP_BACKOFF_O,
	output logic TX_DISCARD_O,
	output logic PAUSE_REQ_O,
	output logic [15:0] PAUSE_TIME_O,
	output logic [47:0] PAUSE_SA_O,
	output logic STORM_LIMIT_O,
	output logic SELF_DROP_O,
	output logic FAIR_MODE_O,
	output logic AGGR_BACKOFF_O,
	output logic PASS_PAUSE_O
);
	localparam int GAP_B = cong_pkg::CRS_GAP_CYC + 1;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [6:0] glob;
	logic [3:0] port;
	logic [47:0] mac;
	logic [23:0] storm_thr;
	logic [23:0] byte_cnt;
	logic congested, pause_on, col_hold, bp_req;
	logic strap_s1, strap_s2;
	logic [1:0] strap_cnt;
	logic wr_pend;
	logic [7:0] wr_off;
	logic [31:0] rd_data;
	logic [31:0] status;
	cong_pkg::bp_state_type bp_state, next_bp_state;

	function automatic logic addr_ok(input logic [31:0] a);
		addr_ok = (a[31:8] == 24'h0) && (a[1:0] == 2'h0);
	endfunction

	wire addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;

	assign status = {27'h0, col_hold, congested, STORM_LIMIT_O, pause_on,
		CRS_FORCE_O};

	always_comb begin
		rd_data = 32'h0;
		case (HADDR_I[7:0])
			cong_pkg::OFF_GLOBAL: rd_data = {25'h0, glob};
			cong_pkg::OFF_PORT: rd_data = {28'h0, port};
			cong_pkg::OFF_MAC_LO: rd_data = mac[31:0];
			cong_pkg::OFF_MAC_HI: rd_data = {16'h0, mac[47:32]};
			cong_pkg::OFF_STORM_THR: rd_data = {8'h0, storm_thr};
			cong_pkg::OFF_STATUS: rd_data = status;
			cong_pkg::OFF_STORM_CNT: rd_data = {8'h0, byte_cnt};
			default: rd_data = 32'h0;
		endcase
		if (!addr_ok(HADDR_I)) begin
			rd_data = 32'h0;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			HRDATA_O <= 32'h0;
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			wr_pend <= 1'b0;
			wr_off <= 8'hff;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			wr_pend <= addr_phase && HWRITE_I && addr_ok(HADDR_I);
			wr_off <= HADDR_I[7:0];
			if (addr_phase && !HWRITE_I) begin
				HRDATA_O <= rd_data;
			end
		end
	end

	// ----------------------------------------
	// Strap capture and control registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			strap_s1 <= 1'b0;
			strap_s2 <= 1'b0;
		end else begin
			strap_s1 <= FLOW_CTRL_STRAP_PIN_I;
			strap_s2 <= strap_s1;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			strap_cnt <= 2'h0;
			glob <= cong_pkg::GLOBAL_RESET;
			port <= cong_pkg::PORT_RESET;
			mac <= cong_pkg::MAC_RESET;
			storm_thr <= cong_pkg::STORM_THR_RESET;
		end else begin
			if (strap_cnt != cong_pkg::STRAP_WAIT) begin
				strap_cnt <= strap_cnt + 2'h1;
			end
			if (strap_cnt == cong_pkg::STRAP_WAIT - 2'h1) begin
				port[cong_pkg::P_FLOW_EN] <= strap_s2;
				port[cong_pkg::P_BP_EN] <= strap_s2;
			end
			if (wr_pend) begin
				case (wr_off)
					cong_pkg::OFF_GLOBAL: glob <= HWDATA_I[6:0];
					cong_pkg::OFF_PORT: port <= HWDATA_I[3:0];
					cong_pkg::OFF_MAC_LO: mac[31:0] <= HWDATA_I;
					cong_pkg::OFF_MAC_HI: mac[47:32] <= HWDATA_I[15:0];
					cong_pkg::OFF_STORM_THR: storm_thr <= HWDATA_I[23:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			FAIR_MODE_O <= 1'b0;
			AGGR_BACKOFF_O <= 1'b0;
			PASS_PAUSE_O <= 1'b0;
		end else begin
			FAIR_MODE_O <= glob[cong_pkg::G_FAIR];
			AGGR_BACKOFF_O <= glob[cong_pkg::G_AGGR_BACKOFF];
			PASS_PAUSE_O <= glob[cong_pkg::G_PASS_PAUSE];
		end
	end

	// ----------------------------------------
	// Resource state and PAUSE
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			congested <= 1'b0;
			pause_on <= 1'b0;
			PAUSE_REQ_O <= 1'b0;
			PAUSE_TIME_O <= cong_pkg::PAUSE_ZERO;
			PAUSE_SA_O <= cong_pkg::MAC_RESET;
		end else begin
			PAUSE_REQ_O <= 1'b0;
			PAUSE_SA_O <= mac;
			// Separate start and stop levels give hysteresis
			if (RES_SHORT_I) begin
				congested <= 1'b1;
			end else if (RES_OK_I) begin
				congested <= 1'b0;
			end
			if (congested && !pause_on && FULL_DUPLEX_I &&
				port[cong_pkg::P_FLOW_EN]) begin
				pause_on <= 1'b1;
				PAUSE_REQ_O <= 1'b1;
				PAUSE_TIME_O <= cong_pkg::PAUSE_MAX;
			end else if (!congested && pause_on) begin
				pause_on <= 1'b0;
				PAUSE_REQ_O <= 1'b1;
				PAUSE_TIME_O <= cong_pkg::PAUSE_ZERO;
			end
		end
	end

	// ----------------------------------------
	// Half-duplex carrier back pressure
	// ----------------------------------------
	logic [11:0] crs_cnt;
	wire bp_want = congested && !FULL_DUPLEX_I && port[cong_pkg::P_BP_EN] &&
		glob[cong_pkg::G_BP_MODE];

	always_comb begin
		next_bp_state = bp_state;
		case (bp_state)
			cong_pkg::BP_IDLE: begin
				if (bp_req) begin
					next_bp_state =
						(TX_PENDING_I && !col_hold && !COLLISION_I) ?
						cong_pkg::BP_YIELD : cong_pkg::BP_CARRIER;
				end
			end
			cong_pkg::BP_CARRIER: begin
				if (!bp_req) begin
					next_bp_state = cong_pkg::BP_IDLE;
				end else if (TX_PENDING_I && !col_hold && !COLLISION_I) begin
					next_bp_state = cong_pkg::BP_YIELD;
				end else if (crs_cnt == 12'(cong_pkg::CRS_MAX_CYC - 1)) begin
					next_bp_state = cong_pkg::BP_GAP;
				end
			end
			cong_pkg::BP_GAP: begin
				if (!bp_req) begin
					next_bp_state = cong_pkg::BP_IDLE;
				end else if (COLLISION_I) begin
					next_bp_state = cong_pkg::BP_CARRIER;
				end else if (TX_PENDING_I && !col_hold) begin
					// Queued frames win over the end of the gap
					next_bp_state = cong_pkg::BP_YIELD;
				end else if (crs_cnt == 12'(cong_pkg::CRS_GAP_CYC - 1)) begin
					next_bp_state = cong_pkg::BP_CARRIER;
				end
			end
			cong_pkg::BP_YIELD: begin
				if (!bp_req) begin
					next_bp_state = cong_pkg::BP_IDLE;
				end else if (col_hold || COLLISION_I ||
					(!TX_PENDING_I && !TX_BUSY_I)) begin
					next_bp_state = cong_pkg::BP_CARRIER;
				end
			end
			default: next_bp_state = cong_pkg::BP_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bp_req <= 1'b0;
			col_hold <= 1'b0;
			bp_state <= cong_pkg::BP_IDLE;
			crs_cnt <= 12'h0;
			CRS_FORCE_O <= 1'b0;
			SKIP_BACKOFF_O <= 1'b0;
		end else begin
			bp_req <= bp_want;
			bp_state <= next_bp_state;
			crs_cnt <= (next_bp_state != bp_state) ? 12'h0 : crs_cnt + 12'h1;
			CRS_FORCE_O <= next_bp_state == cong_pkg::BP_CARRIER;
			SKIP_BACKOFF_O <= bp_req;
			if (!bp_req) begin
				col_hold <= 1'b0;
			end else if (COLLISION_I) begin
				col_hold <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Excessive collision discard
	// ----------------------------------------
	logic [4:0] col_cnt;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			col_cnt <= 5'h0;
			TX_DISCARD_O <= 1'b0;
		end else begin
			TX_DISCARD_O <= 1'b0;
			if (TX_DONE_I) begin
				col_cnt <= 5'h0;
			end else if (COLLISION_I && !bp_req) begin
				if (col_cnt == cong_pkg::COL_LIMIT - 5'h1) begin
					col_cnt <= 5'h0;
					TX_DISCARD_O <= !glob[cong_pkg::G_NO_EXC_DROP];
				end else begin
					col_cnt <= col_cnt + 5'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Storm protection
	// ----------------------------------------
	logic [31:0] ivl_cnt;
	wire [31:0] ivl_last = SPEED_100_I ? INTERVAL_100_CYC - 32'h1 :
		INTERVAL_10_CYC - 32'h1;
	wire ivl_wrap = ivl_cnt >= ivl_last;
	wire storm_class = RX_BCAST_I ||
		(RX_MCAST_I && glob[cong_pkg::G_STORM_MCAST]);

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ivl_cnt <= 32'h0;
			byte_cnt <= 24'h0;
			STORM_LIMIT_O <= 1'b0;
		end else begin
			ivl_cnt <= ivl_wrap ? 32'h0 : ivl_cnt + 32'h1;
			if (ivl_wrap) begin
				byte_cnt <= 24'h0;
				STORM_LIMIT_O <= 1'b0;
			end else begin
				if (RX_BYTE_I && storm_class && port[cong_pkg::P_STORM_EN] &&
					byte_cnt < storm_thr) begin
					byte_cnt <= byte_cnt + 24'h1;
				end
				STORM_LIMIT_O <= port[cong_pkg::P_STORM_EN] &&
					byte_cnt >= storm_thr;
			end
		end
	end

	// ----------------------------------------
	// Self-address filtering
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			SELF_DROP_O <= 1'b0;
		end else begin
			SELF_DROP_O <= RX_SA_VALID_I && RX_SA_I == mac &&
				glob[cong_pkg::G_SELF_FILTER] &&
				port[cong_pkg::P_SELF_FILTER];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic [12:0] crs_run;
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			crs_run <= 13'h0;
		end else begin
			crs_run <= CRS_FORCE_O ? crs_run + 13'h1 : 13'h0;
		end
	end

	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_crs_run_bound: assert property (crs_run <= 13'(cong_pkg::CRS_MAX_CYC))
		else $error("carrier held too long");
	a_gap_short: assert property (bp_state == cong_pkg::BP_GAP |->
		##[1:GAP_B] bp_state != cong_pkg::BP_GAP)
		else $error("silent gap too long");
	a_crs_needs_req: assert property (CRS_FORCE_O |-> $past(bp_req))
		else $error("carrier without back pressure");
	a_tx_yield: assert property (bp_req && TX_PENDING_I && !col_hold &&
		!COLLISION_I |=> !CRS_FORCE_O)
		else $error("carrier not yielded to transmit");
	a_resume_carrier: assert property (bp_state == cong_pkg::BP_YIELD &&
		bp_want && bp_req && !TX_PENDING_I && !TX_BUSY_I |=>
		CRS_FORCE_O)
		else $error("carrier not resumed");
	a_col_carrier: assert property (COLLISION_I && bp_req && bp_want |=>
		CRS_FORCE_O || !bp_req)
		else $error("no carrier after collision");
	a_pause_sa: assert property (PAUSE_REQ_O |-> PAUSE_SA_O == $past(mac))
		else $error("pause source address wrong");
	a_pause_time: assert property (PAUSE_REQ_O |->
		(PAUSE_TIME_O == cong_pkg::PAUSE_MAX) == pause_on)
		else $error("pause time wrong");
	a_storm_clear: assert property (ivl_wrap |=> byte_cnt == 24'h0)
		else $error("storm counter not cleared");
	a_self_drop: assert property (RX_SA_VALID_I && RX_SA_I == mac &&
		glob[cong_pkg::G_SELF_FILTER] && port[cong_pkg::P_SELF_FILTER]
		|=> SELF_DROP_O)
		else $error("self address frame not dropped");
	a_exc_drop: assert property (TX_DISCARD_O |->
		!$past(glob[cong_pkg::G_NO_EXC_DROP]))
		else $error("discard while drop disabled");

	c_gap: cover property (bp_state == cong_pkg::BP_GAP ##1
		bp_state == cong_pkg::BP_CARRIER);
	c_yield: cover property (bp_state == cong_pkg::BP_YIELD ##[1:50]
		bp_state == cong_pkg::BP_CARRIER);
	c_storm: cover property (STORM_LIMIT_O);
	c_pause: cover property (PAUSE_REQ_O && PAUSE_TIME_O == 16'h0);
endmodule

/* shared/cong_pkg.sv */
// Constants for the per-port congestion and ingress protection block
package cong_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int STORM_INTERVAL_100_MS = 50;
	localparam int STORM_INTERVAL_10_MS = 500;
	localparam int CRS_MAX_NS = 40000;
	localparam int CRS_GAP_NS = 400;
	localparam int CRS_MAX_CYC = CRS_MAX_NS / CLK_PERIOD_NS;
	localparam int CRS_GAP_CYC = CRS_GAP_NS / CLK_PERIOD_NS;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [4:0] COL_LIMIT = 5'h10;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_GLOBAL = 8'h00;
	localparam logic [7:0] OFF_PORT = 8'h04;
	localparam logic [7:0] OFF_MAC_LO = 8'h08;
	localparam logic [7:0] OFF_MAC_HI = 8'h0c;
	localparam logic [7:0] OFF_STORM_THR = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_STORM_CNT = 8'h18;
	// ----------------------------------------
	// Global control bits
	// ----------------------------------------
	localparam int G_BP_MODE = 0;
	localparam int G_FAIR = 1;
	localparam int G_NO_EXC_DROP = 2;
	localparam int G_AGGR_BACKOFF = 3;
	localparam int G_PASS_PAUSE = 4;
	localparam int G_SELF_FILTER = 5;
	localparam int G_STORM_MCAST = 6;
	localparam int G_WIDTH = 7;
	localparam logic [6:0] GLOBAL_RESET = 7'h01;
	// ----------------------------------------
	// Port control bits
	// ----------------------------------------
	localparam int P_FLOW_EN = 0;
	localparam int P_BP_EN = 1;
	localparam int P_STORM_EN = 2;
	localparam int P_SELF_FILTER = 3;
	localparam int P_WIDTH = 4;
	localparam logic [3:0] PORT_RESET = 4'h0;
	// ----------------------------------------
	// Other reset values
	// ----------------------------------------
	localparam logic [47:0] MAC_RESET = 48'h0;
	localparam logic [23:0] STORM_THR_RESET = 24'h00186a;
	localparam logic [15:0] PAUSE_MAX = 16'hffff;
	localparam logic [15:0] PAUSE_ZERO = 16'h0000;
	typedef enum {BP_IDLE, BP_CARRIER, BP_GAP, BP_YIELD} bp_state_type;
endpackage

/* tb/eth_peer_model.sv */
// Model of another station sharing the port's medium
`timescale 1ns/1ps
module eth_peer_model (
	input wire logic clk_i,
	input wire logic crs_i,
	output logic byte_o,
	output logic bcast_o,
	output logic mcast_o,
	output logic sa_valid_o,
	output logic [47:0] sa_o,
	output logic col_o
);
	initial begin
		{byte_o, bcast_o, mcast_o, sa_valid_o, col_o} = 5'h0;
		sa_o = 48'h0;
	end

	// Defers on carrier, waits gap cycles, then sends n bytes
	task automatic frame(input logic [47:0] sa, input logic bc,
		input logic mc, input int n, input int gap);
		int i;
		while (crs_i === 1'b1) @(posedge clk_i);
		bcast_o <= bc;
		mcast_o <= mc;
		sa_o <= sa;
		sa_valid_o <= 1'b1;
		@(posedge clk_i);
		sa_valid_o <= 1'b0;
		sa_o <= ~sa;
		repeat (gap) @(posedge clk_i);
		for (i = 0; i < n; i++) begin
			byte_o <= 1'b1;
			@(posedge clk_i);
		end
		byte_o <= 1'b0;
		bcast_o <= ~bc;
		mcast_o <= ~mc;
		@(posedge clk_i);
	endtask

	task automatic collide();
		col_o <= 1'b1;
		@(posedge clk_i);
		col_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

/* tb/mac_port_congestion_ctrl_tb.sv */
// Self-checking bench for the port congestion control block
`timescale 1ns/1ps
module mac_port_congestion_ctrl_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int IV100 = 100;
	localparam int IV10 = 1000;
	localparam int RUN = cong_pkg::CRS_MAX_CYC;
	localparam int GAP = cong_pkg::CRS_GAP_CYC;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd, g;
	logic hready, hresp, crs, skip, disc, preq, slim, sdrop;
	logic [15:0] ptime;
	logic [47:0] psa, sa, mac;
	logic rbyte, rbc, rmc, sav, col, fair, aggr, pass;
	logic short_r = 1'b0;
	logic ok_r = 1'b0;
	logic fdx = 1'b0;
	logic spd = 1'b1;
	logic pend = 1'b0;
	logic busy = 1'b0;
	logic txdone = 1'b0;
	logic strap = 1'b1;
	logic [15:0] sd = 16'h129b;
	logic [31:0] rv [8] = '{{25'h0, cong_pkg::GLOBAL_RESET}, 32'h3, 32'h0,
		32'h0, {8'h0, cong_pkg::STORM_THR_RESET}, 32'h0, 32'h0, 32'h0};
	int fail_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int drops = 0;
	int discs = 0;
	int waited, thr;
	wire [2:0] mon = {slim, preq, crs};

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sdrop === 1'b1) drops <= drops + 1;
		if (disc === 1'b1) discs <= discs + 1;
	end

	mac_port_congestion_ctrl #(.INTERVAL_100_CYC(IV100),
		.INTERVAL_10_CYC(IV10)) uut (
		.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp),
		.FLOW_CTRL_STRAP_PIN_I(strap), .RES_SHORT_I(short_r), .RES_OK_I(ok_r),
		.FULL_DUPLEX_I(fdx), .SPEED_100_I(spd), .TX_PENDING_I(pend),
		.TX_BUSY_I(busy), .COLLISION_I(col), .TX_DONE_I(txdone),
		.RX_BYTE_I(rbyte), .RX_BCAST_I(rbc), .RX_MCAST_I(rmc),
		.RX_SA_VALID_I(sav), .RX_SA_I(sa), .CRS_FORCE_O(crs),
		.SKIP_BACKOFF_O(skip), .TX_DISCARD_O(disc), .PAUSE_REQ_O(preq),
		.PAUSE_TIME_O(ptime), .PAUSE_SA_O(psa), .STORM_LIMIT_O(slim),
		.SELF_DROP_O(sdrop), .FAIR_MODE_O(fair), .AGGR_BACKOFF_O(aggr),
		.PASS_PAUSE_O(pass));

	eth_peer_model peer (.clk_i(clk), .crs_i(crs), .byte_o(rbyte),
		.bcast_o(rbc), .mcast_o(rmc), .sa_valid_o(sav), .sa_o(sa),
		.col_o(col));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string nm, input logic [47:0] seen,
		input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
		chk("hresp", hresp, 1'b0);
	endtask

	task automatic wt(input int i, input logic v, input int lim);
		waited = 0;
		do begin
			@(negedge clk);
			waited++;
		end while (mon[i] !== v && waited <= lim);
	endtask

	task automatic coll(input int n);
		repeat (n) peer.collide();
		repeat (3) @(posedge clk);
	endtask

	task automatic storm_period(input int iv);
		int t;
		@(posedge clk);
		peer.frame(~mac, 1'b1, 1'b0, 2 * thr + 8, 0);
		wt(2, 1'b1, 2 * iv);
		wt(2, 1'b0, iv + 5);
		t = cyc;
		@(posedge clk);
		peer.frame(~mac, 1'b1, 1'b0, thr + 4, 3);
		wt(2, 1'b1, iv);
		wt(2, 1'b0, iv + 5);
		chk("storm_period", cyc - t, iv);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#500000;
		fail_count++;
		finish_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int i;
		int t;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		for (i = 0; i < 8; i++) rchk("reg_reset", 8'(4 * i), rv[i]);
		ahb(1'b1, 8'h1c, 32'hffffffff);
		ahb(1'b1, 8'h14, 32'hffffffff);
		rchk("unmapped", 8'h1c, 32'h0);
		rchk("status_ro", 8'h14, 32'h0);
		for (i = 0; i < 3; i++) begin
			sd = lfsr(sd);
			mac = {mac[31:0], sd};
		end
		ahb(1'b1, 8'h08, mac[31:0]);
		ahb(1'b1, 8'h0c, {16'h0, mac[47:32]});
		rchk("mac_hi", 8'h0c, {16'h0, mac[47:32]});
		sd = lfsr(sd);
		g = {25'h0, sd[6:0]};
		ahb(1'b1, 8'h00, g);
		rchk("global", 8'h00, g);
		chk("outs", {fair, aggr, pass}, {g[1], g[3], g[4]});
		g = 32'h1;
		ahb(1'b1, 8'h00, g);
		$display("registers done");

		@(posedge clk);
		fdx <= 1'b1;
		short_r <= 1'b1;
		wt(1, 1'b1, 6);
		chk("pause_max", ptime, cong_pkg::PAUSE_MAX);
		chk("pause_sa", psa, mac);
		wt(0, 1'b1, 8);
		chk("fdx_no_crs", waited > 8, 1'b1);
		@(posedge clk);
		short_r <= 1'b0;
		ok_r <= 1'b1;
		wt(1, 1'b1, 6);
		chk("pause_zero", ptime, cong_pkg::PAUSE_ZERO);
		@(posedge clk);
		ok_r <= 1'b0;
		fdx <= 1'b0;
		$display("pause done");

		t = discs;
		coll(15);
		chk("disc_15", discs - t, 0);
		coll(1);
		chk("disc_16", discs - t, 1);
		coll(10);
		txdone <= 1'b1;
		@(posedge clk);
		txdone <= 1'b0;
		coll(10);
		chk("disc_done", discs - t, 1);
		g = 32'h5;
		ahb(1'b1, 8'h00, g);
		ahb(1'b1, 8'h04, 32'h7);
		coll(16);
		chk("disc_off", discs - t, 1);
		$display("collisions done");

		@(posedge clk);
		short_r <= 1'b1;
		wt(0, 1'b1, 10);
		chk("crs_latency", waited, 4);
		chk("skip_backoff", skip, 1'b1);
		t = cyc;
		wt(0, 1'b0, RUN + 100);
		chk("crs_run", cyc - t >= RUN - 2 && cyc - t <= RUN + 2, 1'b1);
		t = cyc;
		wt(0, 1'b1, 100);
		chk("crs_gap", cyc - t >= GAP - 2 && cyc - t <= GAP + 2, 1'b1);
		chk("gap_ipg", cyc - t < 96, 1'b1);
		@(posedge clk);
		pend <= 1'b1;
		wt(0, 1'b0, 3);
		chk("yield_tx", waited <= 3, 1'b1);
		@(posedge clk);
		pend <= 1'b0;
		busy <= 1'b1;
		wt(0, 1'b1, 6);
		chk("wait_busy", waited > 6, 1'b1);
		@(posedge clk);
		busy <= 1'b0;
		wt(0, 1'b1, 3);
		chk("resume", waited <= 3, 1'b1);
		@(posedge clk);
		pend <= 1'b1;
		wt(0, 1'b0, 3);
		@(posedge clk);
		peer.collide();
		wt(0, 1'b1, 3);
		chk("col_crs", waited <= 3, 1'b1);
		wt(0, 1'b0, 20);
		chk("col_hold", waited > 20, 1'b1);
		@(posedge clk);
		short_r <= 1'b0;
		ok_r <= 1'b1;
		wt(0, 1'b0, 10);
		chk("crs_stop", waited, 4);
		@(posedge clk);
		ok_r <= 1'b0;
		pend <= 1'b0;
		$display("back pressure done");

		sd = lfsr(sd);
		thr = 3 + int'(sd[2:0]);
		ahb(1'b1, 8'h10, thr);
		storm_period(IV100);
		@(posedge clk);
		spd <= 1'b0;
		storm_period(IV10);
		t = cyc;
		@(posedge clk);
		peer.frame(~mac, 1'b0, 1'b1, thr + 4, 0);
		rchk("storm_mc_off", 8'h18, 32'h0);
		g = 32'h45;
		ahb(1'b1, 8'h00, g);
		while (cyc < t + IV10 + 2) @(posedge clk);
		peer.frame(~mac, 1'b0, 1'b1, thr + 4, 0);
		rchk("storm_cnt", 8'h18, thr);
		chk("storm_limit", slim, 1'b1);
		$display("storm done");

		g = 32'h25;
		ahb(1'b1, 8'h00, g);
		ahb(1'b1, 8'h04, 32'hf);
		t = drops;
		@(posedge clk);
		peer.frame(mac, 1'b0, 1'b0, 0, 0);
		@(posedge clk);
		chk("self_drop", drops - t, 1);
		peer.frame(mac ^ 48'h1, 1'b0, 1'b0, 0, 0);
		@(posedge clk);
		chk("other_sa", drops - t, 1);
		$display("self filter done");

		strap <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		rchk("strap_low", 8'h04, 32'h0);
		rchk("thr_reset", 8'h10, {8'h0, cong_pkg::STORM_THR_RESET});
		chk("crs_reset", crs, 1'b0);
		$display("reset done");
		finish_test();
	end
endmodule
